// ---- src/tbc_core.sv ----
// 16-bit timer core with shared high-byte holding register on APB
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tbc_core
  import tbc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_count_pin,
  input  wire logic        snapshot_input_pin,
  input  wire logic        comparator_out,
  output logic             irq_ovf,
  output logic             irq_match_a,
  output logic             irq_match_b,
  output logic             irq_snapshot,
  output logic             match_hit_a,
  output logic             match_hit_b,
  output logic             pwm_out_a_enable
);
  typedef struct packed {
    logic [15:0] tick_count_value;
    logic [15:0] match_value_a;
    logic [15:0] match_value_b;
    logic [15:0] match_buf_a;
    logic [15:0] match_buf_b;
    logic [15:0] snapshot_value;
    logic [7:0]  hold_hi;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [7:0]  timer_flag_reg;
    logic [7:0]  timer_mask_reg;
    logic        count_down;
    logic [9:0]  prescale;
    logic        tap_prev;
    logic        ext_prev;
    logic        cap_prev;
    logic [3:0]  nc_hist;
    logic        nc_out;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic [3:0]  irq;
    logic        hit_a;
    logic        hit_b;
    logic        pwm_a_en;
  } tbc_core_s;

  tbc_core_s r;
  tbc_core_s next_r;
  logic      ext_sync;
  logic      cap_sync;
  logic      acmp_sync;

  // External tick and capture sources cross from pins
  tbc_sync u_sync_ext (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (external_count_pin),
    .dout    (ext_sync)
  );
  tbc_sync u_sync_cap (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (snapshot_input_pin),
    .dout    (cap_sync)
  );
  tbc_sync u_sync_acmp (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (comparator_out),
    .dout    (acmp_sync)
  );

  always_comb begin
    logic        setup;
    logic        wr;
    logic        rd;
    logic [7:0]  wb;
    logic [2:0]  cs;
    logic [3:0]  wgm;
    logic        tap;
    logic        timer_tick;
    logic [15:0] top;
    logic        at_top;
    logic        at_floor;
    logic        at_max;
    logic        pwm;
    logic        dual;
    logic        top_a;
    logic        top_snap;
    logic        cap_src;
    logic        cap_edge;
    logic [7:0]  fset;
    logic [7:0]  fclr;
    logic [15:0] cnt_next;
    setup      = 1'b0;
    wr         = 1'b0;
    rd         = 1'b0;
    wb         = 8'h00;
    cs         = 3'h0;
    wgm        = 4'h0;
    tap        = 1'b0;
    timer_tick = 1'b0;
    top        = CNT_MAX;
    at_top     = 1'b0;
    at_floor   = 1'b0;
    at_max     = 1'b0;
    pwm        = 1'b0;
    dual       = 1'b0;
    top_a      = 1'b0;
    top_snap   = 1'b0;
    cap_src    = 1'b0;
    cap_edge   = 1'b0;
    fset       = 8'h00;
    fclr       = 8'h00;
    cnt_next   = r.tick_count_value;
    next_r     = r;

    // APB: answer in the cycle after setup, zero wait state
    setup        = psel && !penable;
    next_r.ready = setup;
    wr           = psel && penable && r.ready && pwrite;
    rd           = setup && !pwrite;
    wb           = pwdata[7:0];
    cs  = r.ctrl_b[CS_LSB +: 3];
    wgm = {r.ctrl_b[WGM_B_LSB +: 2], r.ctrl_a[WGM_A_LSB +: 2]};

    // Free-running prescaler; tick on rising tap edge
    next_r.prescale = r.prescale + 10'h001;
    case (cs)
      CS_DIV8:    tap = r.prescale[TAP8];
      CS_DIV64:   tap = r.prescale[TAP64];
      CS_DIV256:  tap = r.prescale[TAP256];
      CS_DIV1024: tap = r.prescale[TAP1024];
      default:    tap = 1'b0;
    endcase
    next_r.tap_prev = tap;
    next_r.ext_prev = ext_sync;
    case (cs)
      CS_STOP:    timer_tick = 1'b0;
      CS_DIV1:    timer_tick = 1'b1;
      CS_EXT_NEG: timer_tick = r.ext_prev && !ext_sync;
      CS_EXT_POS: timer_tick = !r.ext_prev && ext_sync;
      default:    timer_tick = tap && !r.tap_prev;
    endcase

    // Mode decode for top value
    case (wgm)
      WGM_P8, WGM_F8:                       top = TOP_8BIT;
      WGM_P9, WGM_F9:                       top = TOP_9BIT;
      WGM_P10, WGM_F10:                     top = TOP_10BIT;
      WGM_CTC_A, WGM_PF_A, WGM_PC_A, WGM_FP_A: top = r.match_value_a;
      WGM_PF_S, WGM_PC_S, WGM_CTC_S, WGM_FP_S: top = r.snapshot_value;
      default:                              top = CNT_MAX;
    endcase
    top_a    = (wgm == WGM_CTC_A) || (wgm == WGM_PF_A) ||
               (wgm == WGM_PC_A) || (wgm == WGM_FP_A);
    top_snap = (wgm == WGM_PF_S) || (wgm == WGM_PC_S) ||
               (wgm == WGM_CTC_S) || (wgm == WGM_FP_S);
    pwm      = (wgm != WGM_NORMAL) && (wgm != WGM_CTC_A) &&
               (wgm != WGM_CTC_S);
    dual     = (wgm == WGM_P8) || (wgm == WGM_P9) || (wgm == WGM_P10) ||
               (wgm == WGM_PF_S) || (wgm == WGM_PF_A) ||
               (wgm == WGM_PC_S) || (wgm == WGM_PC_A);
    at_max   = r.tick_count_value == CNT_MAX;
    at_floor = r.tick_count_value == CNT_FLOOR;
    at_top   = r.tick_count_value == top;

    // Counter sequence
    if (timer_tick) begin
      if (dual) begin
        if (!r.count_down && at_top) begin
          next_r.count_down = 1'b1;
          cnt_next = r.tick_count_value - 16'h0001;
        end else if (r.count_down && at_floor) begin
          next_r.count_down = 1'b0;
          cnt_next = r.tick_count_value + 16'h0001;
          fset[F_OVF] = 1'b1;
        end else if (r.count_down) begin
          cnt_next = r.tick_count_value - 16'h0001;
        end else begin
          cnt_next = r.tick_count_value + 16'h0001;
        end
      end else if (at_top) begin
        cnt_next = CNT_FLOOR;
        fset[F_OVF] = at_max || pwm;
      end else begin
        cnt_next = r.tick_count_value + 16'h0001;
      end
    end else begin
      cnt_next = r.tick_count_value;
    end
    next_r.tick_count_value = cnt_next;

    // Continuous compare, results feed waveform logic
    next_r.hit_a = r.tick_count_value == r.match_value_a;
    next_r.hit_b = r.tick_count_value == r.match_value_b;
    if (timer_tick && next_r.hit_a) begin
      fset[F_MA] = 1'b1;
    end
    if (timer_tick && next_r.hit_b) begin
      fset[F_MB] = 1'b1;
    end
    next_r.pwm_a_en = pwm && !top_a;

    // Double buffers load at top (PWM) or at once otherwise
    if (!pwm || (timer_tick && at_top)) begin
      next_r.match_value_a = r.match_buf_a;
      next_r.match_value_b = r.match_buf_b;
    end

    // Capture path with optional four-sample filter
    cap_src = r.ctrl_a[ACIC_BIT] ? acmp_sync : cap_sync;
    next_r.nc_hist = {r.nc_hist[NC_SAMPLES-2:0], cap_src};
    if (!r.ctrl_b[NC_BIT]) begin
      next_r.nc_out = cap_src;
    end else if (&r.nc_hist) begin
      next_r.nc_out = 1'b1;
    end else if (~|r.nc_hist) begin
      next_r.nc_out = 1'b0;
    end
    next_r.cap_prev = r.nc_out;
    cap_edge = r.ctrl_b[EDGE_BIT] ? (r.nc_out && !r.cap_prev)
                                  : (!r.nc_out && r.cap_prev);
    if (cap_edge && !top_snap) begin
      next_r.snapshot_value = r.tick_count_value;
      fset[F_SNAP] = 1'b1;
    end

    // Register writes
    if (wr) begin
      case (paddr)
        ADDR_CNT_HI, ADDR_MA_HI, ADDR_MB_HI, ADDR_SNAP_HI:
          next_r.hold_hi = wb;
        ADDR_CNT_LO:
          next_r.tick_count_value = {r.hold_hi, wb};
        ADDR_MA_LO:  next_r.match_buf_a = {r.hold_hi, wb};
        ADDR_MB_LO:  next_r.match_buf_b = {r.hold_hi, wb};
        ADDR_SNAP_LO: begin
          if (top_snap) begin
            next_r.snapshot_value = {r.hold_hi, wb};
          end
        end
        ADDR_CTRL_A: next_r.ctrl_a = wb;
        ADDR_CTRL_B: next_r.ctrl_b = wb;
        ADDR_FLAG:   fclr = wb & FLAG_USED;
        ADDR_MASK:   next_r.timer_mask_reg = wb & FLAG_USED;
        default:     next_r.hold_hi = r.hold_hi;
      endcase
    end
    // A new event in the clearing cycle is kept
    next_r.timer_flag_reg = (r.timer_flag_reg & ~fclr) | fset;

    // Reads answered in the access phase from a registered word
    next_r.slverr = 1'b0;
    if (setup) begin
      next_r.rdata = 32'h0000_0000;
      case (paddr)
        ADDR_CNT_LO: begin
          next_r.rdata[7:0] = r.tick_count_value[7:0];
          if (rd) begin
            next_r.hold_hi = r.tick_count_value[15:8];
          end
        end
        ADDR_SNAP_LO: begin
          next_r.rdata[7:0] = r.snapshot_value[7:0];
          if (rd) begin
            next_r.hold_hi = r.snapshot_value[15:8];
          end
        end
        ADDR_CNT_HI, ADDR_SNAP_HI:
          next_r.rdata[7:0] = r.hold_hi;
        ADDR_MA_LO:  next_r.rdata[7:0] = r.match_buf_a[7:0];
        ADDR_MA_HI:  next_r.rdata[7:0] = r.match_buf_a[15:8];
        ADDR_MB_LO:  next_r.rdata[7:0] = r.match_buf_b[7:0];
        ADDR_MB_HI:  next_r.rdata[7:0] = r.match_buf_b[15:8];
        ADDR_CTRL_A: next_r.rdata[7:0] = r.ctrl_a;
        ADDR_CTRL_B: next_r.rdata[7:0] = r.ctrl_b;
        ADDR_FLAG:   next_r.rdata[7:0] = r.timer_flag_reg;
        ADDR_MASK:   next_r.rdata[7:0] = r.timer_mask_reg;
        default:     next_r.slverr = 1'b1;
      endcase
    end
    // Requests gated by their own mask bits
    next_r.irq = {next_r.timer_flag_reg[F_SNAP], next_r.timer_flag_reg[F_MB],
                  next_r.timer_flag_reg[F_MA], next_r.timer_flag_reg[F_OVF]} &
                 {next_r.timer_mask_reg[F_SNAP], next_r.timer_mask_reg[F_MB],
                  next_r.timer_mask_reg[F_MA],
                  next_r.timer_mask_reg[F_OVF]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata           = r.rdata;
  assign pready           = r.ready;
  assign pslverr          = r.slverr;
  assign irq_ovf          = r.irq[0];
  assign irq_match_a      = r.irq[1];
  assign irq_match_b      = r.irq[2];
  assign irq_snapshot     = r.irq[3];
  assign match_hit_a      = r.hit_a;
  assign match_hit_b      = r.hit_b;
  assign pwm_out_a_enable = r.pwm_a_en;
endmodule : tbc_core
`default_nettype wire

// ---- src/tbc_pkg.sv ----
// Shared constants for the 16-bit timer byte-access core
package tbc_pkg;
  // APB byte addresses, one aligned word per byte-wide register
  localparam logic [7:0] ADDR_CNT_LO   = 8'h00;
  localparam logic [7:0] ADDR_CNT_HI   = 8'h04;
  localparam logic [7:0] ADDR_MA_LO    = 8'h08;
  localparam logic [7:0] ADDR_MA_HI    = 8'h0c;
  localparam logic [7:0] ADDR_MB_LO    = 8'h10;
  localparam logic [7:0] ADDR_MB_HI    = 8'h14;
  localparam logic [7:0] ADDR_SNAP_LO  = 8'h18;
  localparam logic [7:0] ADDR_SNAP_HI  = 8'h1c;
  localparam logic [7:0] ADDR_CTRL_A   = 8'h20;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h24;
  localparam logic [7:0] ADDR_FLAG     = 8'h28;
  localparam logic [7:0] ADDR_MASK     = 8'h2c;
  localparam int         NUM_REGS      = 12;
  // Control B fields
  localparam int CS_LSB   = 0;
  localparam int WGM_B_LSB = 3;
  localparam int EDGE_BIT = 6;
  localparam int NC_BIT   = 7;
  // Control A fields
  localparam int WGM_A_LSB = 0;
  localparam int ACIC_BIT  = 2;
  // Clock select codes
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_NEG = 3'h6;
  localparam logic [2:0] CS_EXT_POS = 3'h7;
  // Prescaler tap bits (period = 2^(bit+1))
  localparam int TAP8 = 2;
  localparam int TAP64 = 5;
  localparam int TAP256 = 7;
  localparam int TAP1024 = 9;
  // Flag / mask bit positions
  localparam int F_OVF  = 0;
  localparam int F_MA   = 1;
  localparam int F_MB   = 2;
  localparam int F_SNAP = 5;
  localparam logic [7:0] FLAG_USED = 8'h27;
  // Counter landmarks
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CNT_FLOOR = 16'h0000;
  localparam logic [15:0] TOP_8BIT  = 16'h00ff;
  localparam logic [15:0] TOP_9BIT  = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  // Waveform mode codes (4 bits)
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_P8     = 4'h1;
  localparam logic [3:0] WGM_P9     = 4'h2;
  localparam logic [3:0] WGM_P10    = 4'h3;
  localparam logic [3:0] WGM_CTC_A  = 4'h4;
  localparam logic [3:0] WGM_F8     = 4'h5;
  localparam logic [3:0] WGM_F9     = 4'h6;
  localparam logic [3:0] WGM_F10    = 4'h7;
  localparam logic [3:0] WGM_PF_S   = 4'h8;
  localparam logic [3:0] WGM_PF_A   = 4'h9;
  localparam logic [3:0] WGM_PC_S   = 4'ha;
  localparam logic [3:0] WGM_PC_A   = 4'hb;
  localparam logic [3:0] WGM_CTC_S  = 4'hc;
  localparam logic [3:0] WGM_FP_S   = 4'he;
  localparam logic [3:0] WGM_FP_A   = 4'hf;
  localparam int NC_SAMPLES = 4;
endpackage : tbc_pkg

// ---- src/tbc_sync.sv ----
// Three-stage pin synchroniser with agreement detect
`timescale 1ns/1ps
`default_nettype none
module tbc_sync
  import tbc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } tbc_sync_s;
  tbc_sync_s r;
  tbc_sync_s next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // Only the second and third stages are compared
    if (r.s2 == r.s3) begin
      next_r.q = r.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.q;
endmodule : tbc_sync
`default_nettype wire

// ---- tb/tbc_core_assertions.sv ----
// Bus and holding-register checks on the timer core ports
`timescale 1ns/1ps
`default_nettype none
module tbc_core_assertions
  import tbc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_ovf,
  input wire logic        irq_match_a,
  input wire logic        irq_match_b,
  input wire logic        irq_snapshot
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] hold_copy;
  logic       hold_known;
  wire logic  mapped = paddr <= ADDR_MASK && paddr[1:0] == 2'h0;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  // Tracks only what a high write reveals; a low read other than match A or flags hides the copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_copy  <= 8'h00;
      hold_known <= 1'b1;
    end else if (psel && penable && pready && mapped) begin
      if (pwrite && paddr[2] && paddr < ADDR_SNAP_HI) begin
        hold_copy  <= pwdata[7:0];
        hold_known <= 1'b1;
      end else if (pwrite && paddr == ADDR_SNAP_HI) begin
        hold_known <= 1'b0;
      end else if (!pwrite && !paddr[2] && paddr[4:3] != 2'h1) begin
        hold_known <= 1'b0;
      end
    end
  end
  ready_after_setup_a: assert property (s_setup |=> pready)
    else $error("no answer one cycle after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  unmapped_error_a: assert property (s_setup ##0 !mapped |=> pslverr)
    else $error("unmapped access not refused");
  mapped_no_error_a: assert property (s_setup ##0 mapped |=> !pslverr)
    else $error("mapped access refused");
  upper_bytes_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  mask_gates_irq_a: assert property (s_done ##0 (pwrite &&
      paddr == ADDR_MASK && pwdata[7:0] == 8'h00) |=> ##1
      !(irq_ovf || irq_match_a || irq_match_b || irq_snapshot))
    else $error("request seen with all mask bits clear");
  hold_read_a: assert property (s_done ##0 (!pwrite &&
      paddr == ADDR_CNT_HI && hold_known) |-> prdata[7:0] == hold_copy)
    else $error("counter high read not from holding byte");
endmodule : tbc_core_assertions
bind tbc_core tbc_core_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_ovf(irq_ovf),
  .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
  .irq_snapshot(irq_snapshot)
);
`default_nettype wire

// ---- tb/tbc_cpu_model.sv ----
// Host bus master performing single byte accesses over APB
`timescale 1ns/1ps
`default_nettype none
module tbc_cpu_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // Callers pair the bytes, though the bench interleaves match A reads between counter high accesses
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep looking valid
    paddr   <= ~a;
    pwdata  <= ~{24'h0, d};
  endtask : xfer
endmodule : tbc_cpu_model
`default_nettype wire

// ---- tb/timer16_byte_access_core_tb.sv ----
// Self-checking bench for the timer byte-access core
`timescale 1ns/1ps
`default_nettype none
module timer16_byte_access_core_tb
  import tbc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic ext_pin, snap_pin, cmp_pin, irq_o, irq_a, irq_b, irq_s;
  logic hit_a, hit_b, pwm_en;
  int n_errors = 0;
  int check_count = 0;
  tbc_cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  tbc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_pin(ext_pin), .snapshot_input_pin(snap_pin),
    .comparator_out(cmp_pin), .irq_ovf(irq_o), .irq_match_a(irq_a),
    .irq_match_b(irq_b), .irq_snapshot(irq_s), .match_hit_a(hit_a),
    .match_hit_b(hit_b), .pwm_out_a_enable(pwm_en));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    cpu.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] r;
    logic        e;
    cpu.xfer(1'b0, a, 8'h00, r, e);
    v = r[7:0];
  endtask : rd
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    wr(lo + 8'h04, v[15:8]);
    wr(lo, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 8'h04, v[15:8]);
  endtask : rd16
  // Prescaler taps make the longest part of the run
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    complete_run();
  end
  initial begin
    logic [7:0]  b;
    logic [15:0] v, x;
    logic [31:0] r;
    logic        e;
    int          sh[5] = '{0, 3, 6, 8, 10};
    presetn = 1'b0;
    ext_pin = 1'b0;
    snap_pin = 1'b0;
    cmp_pin = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_CTRL_A + 8'(4 * i), b);
      check("reset value", {8'h0, b}, 16'h0);
    end
    wr16(ADDR_CNT_LO, 16'h1234);
    repeat (50) @(posedge pclk);
    rd16(ADDR_CNT_LO, v);
    check("stopped counter", v, 16'h1234);
    wr16(ADDR_MA_LO, 16'habcd);
    wr(ADDR_CNT_HI, 8'h5a);
    rd16(ADDR_MA_LO, v);
    check("match a", v, 16'habcd);
    rd(ADDR_CNT_HI, b);
    check("holding kept", {8'h0, b}, 16'h005a);
    rd16(ADDR_CNT_LO, v);
    check("holding copy", v, 16'h1234);
    wr(ADDR_CTRL_A, 8'h03);
    rd(ADDR_CTRL_A, b);
    check("control a", {8'h0, b}, 16'h0003);
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_B, 8'h80);
    rd(ADDR_CTRL_B, b);
    check("control b", {8'h0, b}, 16'h0080);
    wr16(ADDR_MA_LO, 16'h0003);
    wr16(ADDR_MB_LO, 16'h0005);
    wr(ADDR_MASK, 8'h01);
    wr16(ADDR_CNT_LO, 16'hfffe);
    wr(ADDR_CTRL_B, 8'(CS_DIV1));
    repeat (8) @(posedge pclk);
    wr(ADDR_CTRL_B, 8'(CS_STOP));
    rd(ADDR_FLAG, b);
    check("flags", {8'h0, b}, 16'h0007);
    repeat (3) @(posedge pclk);
    check("irq ovf on", {15'h0, irq_o}, 16'h1);
    check("irq a masked", {15'h0, irq_a}, 16'h0);
    wr(ADDR_MASK, 8'h06);
    repeat (3) @(posedge pclk);
    check("irq ovf masked", {15'h0, irq_o}, 16'h0);
    check("irq b on", {15'h0, irq_b}, 16'h1);
    // Masking while flags stand exercises the mask gate
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_FLAG, 8'h07);
    rd(ADDR_FLAG, b);
    check("flags cleared", {8'h0, b}, 16'h0);
    for (int s = 0; s < 2; s++) begin
      wr16(ADDR_CNT_LO, 16'h0770 + 16'(s));
      wr(ADDR_CTRL_A, s ? 8'h04 : 8'h00);
      wr(ADDR_CTRL_B, 8'h40);
      wr(ADDR_FLAG, 8'h20);
      if (s) cmp_pin <= 1'b1;
      else snap_pin <= 1'b1;
      repeat (10) @(posedge pclk);
      rd(ADDR_FLAG, b);
      check("capture flag", {8'h0, b}, 16'h0020);
      rd16(ADDR_SNAP_LO, v);
      check("snapshot", v, 16'h0770 + 16'(s));
      cmp_pin <= 1'b0;
      snap_pin <= 1'b0;
    end
    wr(ADDR_MASK, 8'h20);
    repeat (2) @(posedge pclk);
    check("irq snapshot", {15'h0, irq_s}, 16'h1);
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_CTRL_A, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr16(ADDR_CNT_LO, 16'h0000);
      wr(ADDR_CTRL_B, 8'(k ? CS_EXT_POS : CS_EXT_NEG));
      repeat (3) begin
        repeat (4) @(posedge pclk);
        ext_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_pin <= 1'b0;
      end
      repeat (8) @(posedge pclk);
      wr(ADDR_CTRL_B, 8'(CS_STOP));
      rd16(ADDR_CNT_LO, v);
      check("edge count", v, 16'h0003);
    end
    for (int i = 0; i < 5; i++) begin
      wr16(ADDR_CNT_LO, 16'h0000);
      wr(ADDR_CTRL_B, 8'(CS_DIV1) + 8'(i));
      repeat (4096) @(posedge pclk);
      wr(ADDR_CTRL_B, 8'(CS_STOP));
      rd16(ADDR_CNT_LO, v);
      x = 16'(4096 >> sh[i]);
      check("tap count", {15'h0, v + 16'd6 >= x && v <= x + 16'd6},
            16'h1);
    end
    wr16(ADDR_CNT_LO, 16'h0005);
    repeat (2) @(posedge pclk);
    check("hit a", {15'h0, hit_a}, 16'h0);
    check("hit b", {15'h0, hit_b}, 16'h1);
    // Fixed 8-bit top: three ticks from 0xfe wrap through zero
    wr(ADDR_CTRL_A, 8'h01);
    wr16(ADDR_CNT_LO, 16'h00fe);
    wr(ADDR_CTRL_B, 8'h09);
    wr(ADDR_CTRL_B, 8'h08);
    rd16(ADDR_CNT_LO, v);
    check("fixed top", v, 16'h0001);
    check("pwm a enable", {15'h0, pwm_en}, 16'h1);
    // Match A as top: new value waits in the buffer until top
    wr(ADDR_CTRL_A, 8'h03);
    wr(ADDR_CTRL_B, 8'h18);
    wr16(ADDR_CNT_LO, 16'h0003);
    wr16(ADDR_MA_LO, 16'h0010);
    repeat (2) @(posedge pclk);
    check("pwm a as top", {15'h0, pwm_en}, 16'h0);
    check("match a buffered", {15'h0, hit_a}, 16'h1);
    wr(ADDR_CTRL_B, 8'h19);
    wr(ADDR_CTRL_B, 8'h18);
    rd16(ADDR_CNT_LO, v);
    check("match a top", v, 16'h0002);
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_B, 8'h00);
    // Counting resumes at once, so only a small drift is allowed
    wr(ADDR_CTRL_B, 8'(CS_DIV1));
    wr16(ADDR_CNT_LO, 16'h8000);
    wr(ADDR_CTRL_B, 8'(CS_STOP));
    rd16(ADDR_CNT_LO, v);
    check("write while running", {15'h0, v >= 16'h8000 && v <= 16'h8008},
          16'h1);
    cpu.xfer(1'b1, 8'h30, 8'hff, r, e);
    check("unmapped write", {15'h0, e}, 16'h1);
    cpu.xfer(1'b0, 8'h30, 8'h00, r, e);
    check("unmapped read", r[15:0], 16'h0);
    check("unmapped error", {15'h0, e}, 16'h1);
    complete_run();
  end
endmodule : timer16_byte_access_core_tb
`default_nettype wire
